/* File: src/data_flash_pkg.sv */
// constants and carrier types of the data flash access unit
package data_flash_pkg;

	// ************************************************************
	// register indices, byte address is four times the index
	// ************************************************************
	localparam logic [5:0] IDX_OP_START  = 6'h0B;
	localparam logic [5:0] IDX_OP_STATUS = 6'h0C;
	localparam logic [5:0] IDX_ADDR0     = 6'h18;
	localparam logic [5:0] IDX_ADDR1     = 6'h19;
	localparam logic [5:0] IDX_ADDR2     = 6'h1A;
	localparam logic [5:0] IDX_ADDR3     = 6'h1B;
	localparam logic [5:0] IDX_DATA_LO   = 6'h1C;
	localparam logic [5:0] IDX_DATA_HI   = 6'h1D;
	localparam logic [5:0] IDX_ADDR4     = 6'h1E;
	localparam logic [5:0] IDX_IRQ_STAT  = 6'h20;
	localparam logic [5:0] IDX_IRQ_MASK  = 6'h21;

	// ************************************************************
	// field positions and reset values
	// ************************************************************
	localparam int         BIT_WRITE_START = 3;
	localparam int         BIT_ERASE_START = 2;
	localparam int         BIT_DONE_FLAG   = 0;
	localparam int         BIT_DONE_IRQ_EN = 1;
	localparam int         BIT_EV_WRITE    = 0;
	localparam int         BIT_EV_ERASE    = 1;
	localparam logic [3:0] RST_NIBBLE      = 4'h0;
	localparam int         ADDR_W          = 17;
	localparam int         SECTOR_LSB      = 9;

	// ************************************************************
	// timing
	// ************************************************************
	localparam int CLK_PERIOD_NS = 10;
	localparam int T_WRITE_NS    = 47000;
	localparam int T_ERASE_NS    = 3000000;
	localparam int WRITE_CYCLES  = T_WRITE_NS / CLK_PERIOD_NS;
	localparam int ERASE_CYCLES  = T_ERASE_NS / CLK_PERIOD_NS;
	localparam int CNT_W         = 19;

	typedef enum logic [2:0] {
		OP_IDLE  = 3'b001,
		OP_WRITE = 3'b010,
		OP_ERASE = 3'b100
	} op_e;

	typedef struct packed {
		op_e               op;
		logic [CNT_W-1:0]  cnt;
		logic [ADDR_W-1:0] addr;
		logic [ADDR_W-1:0] prog_addr;
		logic [3:0]        hi_nib;
		logic [15:0]       wbuf;
		logic [7:0]        rdata;
		logic              done;
		logic              done_en;
		logic [1:0]        ev_stat;
		logic [1:0]        ev_mask;
		logic [31:0]       prdata;
	} state_s;

endpackage : data_flash_pkg

/* File: src/data_flash_access_unit.sv */
// data flash access unit: nibble registers over APB, address counter, write/erase sequencer
//
// Behaviour
// - five address nibbles form the byte address, nibble 0 lowest
// - only bit 0 of the top address nibble exists, upper bits read zero
// - low data nibble reads bits 3..0, high nibble bits 7..4
// - each write to the low data nibble increments the address
// - writing one to write-start begins programming, bit clears itself
// - writing one to erase-start begins sector erase, bit clears itself
// - completion flag set when write or erase finishes
// - completion interrupt raised while its enable bit is one, or by an unmasked write or erase event
// - start register resets to zero, low two bits read zero
// - last 64 bytes are reserved, hardware does not check
// - contents are bytes, split into two nibbles at the registers
// - sixteen bit buffer filled high then low nibble twice from even address
// - start ignored while completion flag is high
// - programming lasts 47 us and the cpu is held meanwhile
// - erase clears the addressed 512 byte sector, lasts 3 ms
module data_flash_access_unit #(
	parameter int WRITE_CYC = data_flash_pkg::WRITE_CYCLES,
	parameter int ERASE_CYC = data_flash_pkg::ERASE_CYCLES
) (
	// clock and reset
	input  wire logic        i_sys_clk,
	input  wire logic        i_rst,
	// apb slave
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [7:0]  i_paddr,
	input  wire logic [31:0] i_pwdata,
	output logic      [31:0] o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	// flash array macro
	output logic      [17:0] o_fl_addr,
	output logic      [15:0] o_fl_wdata,
	output logic             o_fl_prog,
	output logic             o_fl_erase,
	input  wire logic [7:0]  i_fl_rdata,
	// cpu and interrupt
	output logic             o_cpu_hold,
	output logic             o_irq
);

	// package widths used in slices and casts below
	localparam int CNT_W      = data_flash_pkg::CNT_W;
	localparam int ADDR_W     = data_flash_pkg::ADDR_W;
	localparam int SECTOR_LSB = data_flash_pkg::SECTOR_LSB;

	// ************************************************************
	// decode and helpers
	// ************************************************************
	data_flash_pkg::state_s s_q;
	data_flash_pkg::state_s s_d;
	logic [5:0]             idx;
	logic                   wr_acc;
	logic                   rd_setup;
	logic                   idle;
	logic                   finish;
	logic [1:0]             ev_set;

	// register index is a mapped one
	function automatic logic is_mapped(input logic [5:0] ix);
		case (ix)
			data_flash_pkg::IDX_OP_START, data_flash_pkg::IDX_OP_STATUS,
			data_flash_pkg::IDX_ADDR0, data_flash_pkg::IDX_ADDR1,
			data_flash_pkg::IDX_ADDR2, data_flash_pkg::IDX_ADDR3,
			data_flash_pkg::IDX_DATA_LO, data_flash_pkg::IDX_DATA_HI,
			data_flash_pkg::IDX_ADDR4, data_flash_pkg::IDX_IRQ_STAT,
			data_flash_pkg::IDX_IRQ_MASK: is_mapped = 1'b1;
			default: is_mapped = 1'b0;
		endcase
	endfunction : is_mapped

	// bus phase decode, zero wait states
	assign idx      = i_paddr[7:2];
	assign wr_acc   = i_psel & i_penable & i_pwrite & is_mapped(idx);
	assign rd_setup = i_psel & ~i_penable & ~i_pwrite;
	assign idle     = (s_q.op == data_flash_pkg::OP_IDLE);
	assign finish   = ~idle & (s_q.cnt == '0);
	assign ev_set   = {finish & (s_q.op == data_flash_pkg::OP_ERASE),
	                   finish & (s_q.op == data_flash_pkg::OP_WRITE)};

	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		s_d = s_q;
		s_d.rdata = i_fl_rdata;
		// read data prepared in the setup phase
		if (rd_setup) begin
			case (idx)
				data_flash_pkg::IDX_OP_START:
					s_d.prdata = {28'h0000000, s_q.op == data_flash_pkg::OP_WRITE,
					              s_q.op == data_flash_pkg::OP_ERASE, 2'h0};
				data_flash_pkg::IDX_OP_STATUS: s_d.prdata = {30'h00000000, s_q.done_en, s_q.done};
				data_flash_pkg::IDX_ADDR0:     s_d.prdata = {28'h0000000, s_q.addr[3:0]};
				data_flash_pkg::IDX_ADDR1:     s_d.prdata = {28'h0000000, s_q.addr[7:4]};
				data_flash_pkg::IDX_ADDR2:     s_d.prdata = {28'h0000000, s_q.addr[11:8]};
				data_flash_pkg::IDX_ADDR3:     s_d.prdata = {28'h0000000, s_q.addr[15:12]};
				data_flash_pkg::IDX_ADDR4:     s_d.prdata = {31'h00000000, s_q.addr[16]};
				data_flash_pkg::IDX_DATA_LO:   s_d.prdata = {28'h0000000, s_q.rdata[3:0]};
				data_flash_pkg::IDX_DATA_HI:   s_d.prdata = {28'h0000000, s_q.rdata[7:4]};
				data_flash_pkg::IDX_IRQ_STAT:  s_d.prdata = {30'h00000000, s_q.ev_stat};
				data_flash_pkg::IDX_IRQ_MASK:  s_d.prdata = {30'h00000000, s_q.ev_mask};
				default:                       s_d.prdata = 32'h00000000;
			endcase
		end
		// sequencer countdown
		if (~idle) begin
			s_d.cnt = s_q.cnt - 1'b1;
		end
		if (finish) begin
			s_d.op   = data_flash_pkg::OP_IDLE;
			s_d.cnt  = '0;
		end
		// register writes, ignored while the sequencer runs
		if (wr_acc & idle) begin
			case (idx)
				data_flash_pkg::IDX_OP_START: begin
					if (!s_q.done && i_pwdata[data_flash_pkg::BIT_WRITE_START]) begin
						s_d.op  = data_flash_pkg::OP_WRITE;
						s_d.cnt = CNT_W'(WRITE_CYC - 1);
					end else if (!s_q.done && i_pwdata[data_flash_pkg::BIT_ERASE_START]) begin
						s_d.op  = data_flash_pkg::OP_ERASE;
						s_d.cnt = CNT_W'(ERASE_CYC - 1);
					end
				end
				data_flash_pkg::IDX_OP_STATUS: begin
					s_d.done_en = i_pwdata[data_flash_pkg::BIT_DONE_IRQ_EN];
					if (!i_pwdata[data_flash_pkg::BIT_DONE_FLAG]) begin
						s_d.done = 1'b0;
					end
				end
				data_flash_pkg::IDX_ADDR0: s_d.addr[3:0]   = i_pwdata[3:0];
				data_flash_pkg::IDX_ADDR1: s_d.addr[7:4]   = i_pwdata[3:0];
				data_flash_pkg::IDX_ADDR2: s_d.addr[11:8]  = i_pwdata[3:0];
				data_flash_pkg::IDX_ADDR3: s_d.addr[15:12] = i_pwdata[3:0];
				data_flash_pkg::IDX_ADDR4: s_d.addr[16]    = i_pwdata[0];
				data_flash_pkg::IDX_DATA_HI: s_d.hi_nib = i_pwdata[3:0];
				data_flash_pkg::IDX_DATA_LO: begin
					if (s_q.addr[0]) begin
						s_d.wbuf[15:8] = {s_q.hi_nib, i_pwdata[3:0]};
					end else begin
						s_d.wbuf[7:0]  = {s_q.hi_nib, i_pwdata[3:0]};
					end
					s_d.prog_addr = {s_q.addr[ADDR_W-1:1], 1'b0};
					s_d.addr = s_q.addr + 1'b1;
				end
				data_flash_pkg::IDX_IRQ_MASK: s_d.ev_mask = i_pwdata[1:0];
				// one written clears a sticky event
				data_flash_pkg::IDX_IRQ_STAT: s_d.ev_stat = s_q.ev_stat & ~i_pwdata[1:0];
				default: s_d.addr = s_q.addr;
			endcase
		end
		// set wins over a clear in the same cycle
		if (finish) begin
			s_d.done = 1'b1;
		end
		s_d.ev_stat = s_d.ev_stat | ev_set;
	end

	// ************************************************************
	// state register
	// ************************************************************
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			s_q         <= '0;
			s_q.op      <= data_flash_pkg::OP_IDLE;
			s_q.addr    <= '0;
			s_q.done_en <= data_flash_pkg::RST_NIBBLE[0];
		end else begin
			s_q <= s_d;
		end
	end

	// ************************************************************
	// outputs
	// ************************************************************
	assign o_prdata   = s_q.prdata;
	assign o_pready   = 1'b1;
	assign o_pslverr  = i_psel & i_penable & ~is_mapped(idx);
	assign o_fl_wdata = s_q.wbuf;
	assign o_fl_prog  = (s_q.op == data_flash_pkg::OP_WRITE);
	assign o_fl_erase = (s_q.op == data_flash_pkg::OP_ERASE);
	// sector selected by upper address bits
	always_comb begin
		case (s_q.op)
			data_flash_pkg::OP_WRITE: o_fl_addr = {1'b0, s_q.prog_addr};
			data_flash_pkg::OP_ERASE: o_fl_addr = {1'b0, s_q.addr[ADDR_W-1:SECTOR_LSB], 9'h000};
			default:                  o_fl_addr = {1'b0, s_q.addr};
		endcase
	end
	assign o_cpu_hold = ~idle;
	assign o_irq = (s_q.done & s_q.done_en) | (|(s_q.ev_stat & s_q.ev_mask));

	// ************************************************************
	// assertions
	// ************************************************************
	logic [CNT_W-1:0] run_len;

	// length of the running operation
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			run_len <= '0;
		end else if (idle) begin
			run_len <= '0;
		end else begin
			run_len <= run_len + 1'b1;
		end
	end

	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);

	property p_addr_inc;
		wr_acc && idle && idx == data_flash_pkg::IDX_DATA_LO |=> s_q.addr == $past(s_q.addr) + 1'b1;
	endproperty
	a_addr_inc: assert property (p_addr_inc) else $error("address not incremented");

	property p_addr4_read;
		rd_setup && idx == data_flash_pkg::IDX_ADDR4 |=> o_prdata[31:1] == '0 && o_prdata[0] == s_q.addr[16];
	endproperty
	a_addr4_read: assert property (p_addr4_read) else $error("top address nibble wrong");

	property p_data_hi;
		rd_setup && idx == data_flash_pkg::IDX_DATA_HI |=> o_prdata[3:0] == $past(s_q.rdata[7:4]);
	endproperty
	a_data_hi: assert property (p_data_hi) else $error("high data nibble wrong");

	property p_ready_delay;
		idle && $stable(s_q.addr) ##1 idle |-> s_q.rdata == $past(i_fl_rdata) && o_fl_addr[16:0] == s_q.addr;
	endproperty
	a_ready_delay: assert property (p_ready_delay) else $error("data does not follow address");

	property p_start_blocked;
		wr_acc && idx == data_flash_pkg::IDX_OP_START && s_q.done |=> idle;
	endproperty
	a_start_blocked: assert property (p_start_blocked) else $error("start taken while flag high");

	property p_write_start;
		wr_acc && idle && !s_q.done && idx == data_flash_pkg::IDX_OP_START && i_pwdata[3]
			|=> o_fl_prog ##1 o_fl_prog && o_cpu_hold;
	endproperty
	a_write_start: assert property (p_write_start) else $error("write did not start");

	property p_erase_start;
		wr_acc && idle && !s_q.done && idx == data_flash_pkg::IDX_OP_START && i_pwdata[3:2] == 2'b01
			|=> o_fl_erase;
	endproperty
	a_erase_start: assert property (p_erase_start) else $error("erase did not start");

	property p_op_len;
		finish |-> run_len == CNT_W'((s_q.op == data_flash_pkg::OP_WRITE ? WRITE_CYC : ERASE_CYC) - 1);
	endproperty
	a_op_len: assert property (p_op_len) else $error("operation length wrong");

	property p_done_set;
		finish |=> s_q.done && idle && !o_cpu_hold;
	endproperty
	a_done_set: assert property (p_done_set) else $error("flag not set at completion");

	property p_irq_gate;
		s_q.ev_stat == 2'b00 |-> o_irq == (s_q.done && s_q.done_en);
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("interrupt gating wrong");

	property p_start_low_zero;
		rd_setup && idx == data_flash_pkg::IDX_OP_START |=> o_prdata[1:0] == 2'b00;
	endproperty
	a_start_low_zero: assert property (p_start_low_zero) else $error("start low bits not zero");

	property p_buf_fill;
		wr_acc && idle && idx == data_flash_pkg::IDX_DATA_LO && !s_q.addr[0]
			|=> s_q.wbuf[7:0] == {$past(s_q.hi_nib), $past(i_pwdata[3:0])};
	endproperty
	a_buf_fill: assert property (p_buf_fill) else $error("write buffer byte wrong");

	property p_addr_nibble0;
		wr_acc && idle && idx == data_flash_pkg::IDX_ADDR0 |=> s_q.addr[3:0] == $past(i_pwdata[3:0]);
	endproperty
	a_addr_nibble0: assert property (p_addr_nibble0) else $error("lowest address nibble not loaded");

	property p_addr_nibble3;
		wr_acc && idle && idx == data_flash_pkg::IDX_ADDR3 |=> s_q.addr[15:12] == $past(i_pwdata[3:0]);
	endproperty
	a_addr_nibble3: assert property (p_addr_nibble3) else $error("address nibble three not loaded");

	property p_addr4_write;
		wr_acc && idle && idx == data_flash_pkg::IDX_ADDR4
			|=> s_q.addr[16] == $past(i_pwdata[0]) && s_q.addr[15:0] == $past(s_q.addr[15:0]);
	endproperty
	a_addr4_write: assert property (p_addr4_write) else $error("top address nibble write wrong");

	// the unimplemented address bits never reach the array
	property p_fl_addr_top;
		o_fl_addr[17] == 1'b0;
	endproperty
	a_fl_addr_top: assert property (p_fl_addr_top) else $error("array address top bit set");

	property p_data_lo;
		rd_setup && idx == data_flash_pkg::IDX_DATA_LO |=> o_prdata[3:0] == $past(s_q.rdata[3:0]);
	endproperty
	a_data_lo: assert property (p_data_lo) else $error("low data nibble wrong");

	property p_data_width;
		rd_setup && (idx == data_flash_pkg::IDX_DATA_LO || idx == data_flash_pkg::IDX_DATA_HI)
			|=> o_prdata[31:4] == '0;
	endproperty
	a_data_width: assert property (p_data_width) else $error("data nibble wider than four bits");

	property p_inc_carry;
		wr_acc && idle && idx == data_flash_pkg::IDX_DATA_LO && (&s_q.addr) |=> s_q.addr == '0;
	endproperty
	a_inc_carry: assert property (p_inc_carry) else $error("address overflow not wrapped");

	property p_prog_even;
		o_fl_prog |-> o_fl_addr[0] == 1'b0;
	endproperty
	a_prog_even: assert property (p_prog_even) else $error("program word address odd");

	property p_erase_base;
		o_fl_erase |-> o_fl_addr[8:0] == 9'h000;
	endproperty
	a_erase_base: assert property (p_erase_base) else $error("erase address not a sector base");

	// no range check: the sector comes straight from the address register
	property p_erase_sector;
		o_fl_erase |-> o_fl_addr[16:9] == s_q.addr[16:9];
	endproperty
	a_erase_sector: assert property (p_erase_sector) else $error("erase sector altered");

	// the array address must not move under a running operation
	property p_hold_stable;
		o_cpu_hold |=> !o_cpu_hold || $stable(o_fl_addr);
	endproperty
	a_hold_stable: assert property (p_hold_stable) else $error("array address moved while held");

	property p_done_clear;
		wr_acc && idle && idx == data_flash_pkg::IDX_OP_STATUS && !i_pwdata[data_flash_pkg::BIT_DONE_FLAG]
			|=> !s_q.done;
	endproperty
	a_done_clear: assert property (p_done_clear) else $error("flag not cleared by zero");

	property p_done_sticky;
		s_q.done && !(wr_acc && idle && idx == data_flash_pkg::IDX_OP_STATUS && !i_pwdata[0]) |=> s_q.done;
	endproperty
	a_done_sticky: assert property (p_done_sticky) else $error("flag lost without a clear");

	property p_write_clear;
		finish && o_fl_prog |=> !o_fl_prog;
	endproperty
	a_write_clear: assert property (p_write_clear) else $error("write start did not clear");

	property p_erase_clear;
		finish && o_fl_erase |=> !o_fl_erase;
	endproperty
	a_erase_clear: assert property (p_erase_clear) else $error("erase start did not clear");

	property p_irq_event;
		s_q.ev_stat[1] && s_q.ev_mask[1] |-> o_irq;
	endproperty
	a_irq_event: assert property (p_irq_event) else $error("unmasked event without interrupt");

	c_write_done: cover property ($fell(o_fl_prog) && s_q.done);
	c_erase_done: cover property ($fell(o_fl_erase) && s_q.done);
	c_blocked:    cover property (wr_acc && idx == data_flash_pkg::IDX_OP_START && s_q.done);
	c_irq:        cover property ($rose(o_irq));

endmodule : data_flash_access_unit

/* File: dv/flash_array_model.sv */
// behavioural flash array standing behind the access unit
module flash_array_model #(
	parameter logic [7:0] ERASED_BYTE = 8'hFF
) (
	// clock
	input  wire logic        i_sys_clk,
	// array side of the access unit
	input  wire logic [17:0] i_addr,
	input  wire logic [15:0] i_wdata,
	input  wire logic        i_prog,
	input  wire logic        i_erase,
	output logic      [7:0]  o_rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] mem [0:1023];
	logic       prog_q;
	logic       erase_q;
	// seed contents with a pattern the bench can predict
	initial begin
		for (int i = 0; i < 1024; i++) begin
			mem[i] = 8'(i) ^ 8'h5A;
		end
	end
	assign o_rdata = mem[i_addr[9:0]];
	always @(posedge i_sys_clk) begin
		prog_q <= i_prog;
		erase_q <= i_erase;
		if (i_prog && !prog_q) begin
			mem[{i_addr[9:1], 1'b0}] <= i_wdata[7:0];
			mem[{i_addr[9:1], 1'b1}] <= i_wdata[15:8];
		end
		if (i_erase && !erase_q) begin
			for (int j = 0; j < 512; j++) begin
				mem[{i_addr[9], 9'(j)}] <= ERASED_BYTE;
			end
		end
	end
endmodule : flash_array_model

/* File: dv/test_data_flash_access_unit.sv */
// self-checking bench of the data flash access unit
module test_data_flash_access_unit;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int WC = 10;
	localparam int EC = 20;
	logic        i_sys_clk;
	logic        i_rst;
	logic        i_psel;
	logic        i_penable;
	logic        i_pwrite;
	logic [7:0]  i_paddr;
	logic [31:0] i_pwdata;
	logic [31:0] o_prdata;
	logic        o_pready;
	logic        o_pslverr;
	logic [17:0] o_fl_addr;
	logic [15:0] o_fl_wdata;
	logic        o_fl_prog;
	logic        o_fl_erase;
	logic [7:0]  i_fl_rdata;
	logic        o_cpu_hold;
	logic        o_irq;
	logic [31:0] rd;
	logic        err;
	int          n;
	int          errors;
	int          cmp_count;
	// ************************************************************
	// design and far side
	// ************************************************************
	data_flash_access_unit #(.WRITE_CYC(WC), .ERASE_CYC(EC)) uut (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
		.i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
		.o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .o_fl_addr(o_fl_addr),
		.o_fl_wdata(o_fl_wdata), .o_fl_prog(o_fl_prog), .o_fl_erase(o_fl_erase), .i_fl_rdata(i_fl_rdata),
		.o_cpu_hold(o_cpu_hold), .o_irq(o_irq));
	flash_array_model fam (.i_sys_clk(i_sys_clk), .i_addr(o_fl_addr), .i_wdata(o_fl_wdata),
		.i_prog(o_fl_prog), .i_erase(o_fl_erase), .o_rdata(i_fl_rdata));
	// ************************************************************
	// shared tasks
	// ************************************************************
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask : check
	// one apb transfer, held until pready is seen
	task automatic apb(input logic wr, input logic [5:0] idx, input logic [3:0] wd);
		@(posedge i_sys_clk);
		i_psel <= 1'b1;
		i_pwrite <= wr;
		i_paddr <= {idx, 2'b00};
		i_pwdata <= {28'h0, wd};
		@(posedge i_sys_clk);
		i_penable <= 1'b1;
		do @(posedge i_sys_clk); while (o_pready !== 1'b1);
		rd = o_prdata;
		err = o_pslverr;
		i_psel <= 1'b0;
		i_penable <= 1'b0;
	endtask : apb
	task automatic rdchk(input logic [5:0] idx, input logic [3:0] exp);
		apb(1'b0, idx, 4'h0);
		check(rd, {28'h0, exp});
	endtask : rdchk
	task automatic set_addr(input logic [17:0] a);
		apb(1'b1, data_flash_pkg::IDX_ADDR0, a[3:0]);
		apb(1'b1, data_flash_pkg::IDX_ADDR1, a[7:4]);
		apb(1'b1, data_flash_pkg::IDX_ADDR2, a[11:8]);
		apb(1'b1, data_flash_pkg::IDX_ADDR3, a[15:12]);
		apb(1'b1, data_flash_pkg::IDX_ADDR4, {2'b00, a[17:16]});
		repeat (2) @(posedge i_sys_clk);
	endtask : set_addr
	// count cycles of a running operation, a cyc of zero expects the start refused
	task automatic run_op(input logic [3:0] op, input int cyc);
		apb(1'b1, data_flash_pkg::IDX_OP_START, op);
		@(posedge i_sys_clk);
		#1;
		check(o_cpu_hold, 32'(cyc != 0));
		check({o_fl_prog, o_fl_erase}, (cyc == 0) ? 2'b00 : op[3:2]);
		n = 0;
		while (o_cpu_hold === 1'b1 && n < 400) begin
			@(posedge i_sys_clk);
			#1;
			n++;
		end
		check(n, (cyc == 0) ? 0 : cyc - 1);
	endtask : run_op
	// ************************************************************
	// scenarios
	// ************************************************************
	task automatic t_read;
		rdchk(data_flash_pkg::IDX_OP_START, 4'h0);
		rdchk(data_flash_pkg::IDX_OP_STATUS, 4'h0);
		set_addr(18'h00123);
		check(o_fl_addr, 18'h00123);
		rdchk(data_flash_pkg::IDX_DATA_LO, 4'h9);
		rdchk(data_flash_pkg::IDX_DATA_HI, 4'h7);
		apb(1'b1, data_flash_pkg::IDX_ADDR4, 4'hF);
		rdchk(data_flash_pkg::IDX_ADDR4, 4'h1);
	endtask : t_read
	task automatic t_incr;
		set_addr(18'h1FFFF);
		apb(1'b1, data_flash_pkg::IDX_DATA_LO, 4'h0);
		@(posedge i_sys_clk);
		#1;
		check(o_fl_addr, 18'h0);
		set_addr(18'h000FF);
		apb(1'b1, data_flash_pkg::IDX_DATA_LO, 4'h0);
		repeat (2) @(posedge i_sys_clk);
		rdchk(data_flash_pkg::IDX_ADDR2, 4'h1);
		rdchk(data_flash_pkg::IDX_DATA_LO, 4'hA);
	endtask : t_incr
	task automatic t_prog;
		set_addr(18'h00200); // legal address clear of the reserved top
		apb(1'b1, data_flash_pkg::IDX_DATA_HI, 4'hA);
		apb(1'b1, data_flash_pkg::IDX_DATA_LO, 4'h5);
		apb(1'b1, data_flash_pkg::IDX_DATA_HI, 4'h3);
		apb(1'b1, data_flash_pkg::IDX_DATA_LO, 4'hC);
		apb(1'b1, data_flash_pkg::IDX_OP_START, 4'h0);
		@(posedge i_sys_clk);
		#1;
		check(o_cpu_hold, 0);
		check(o_fl_wdata, 32'h00003CA5);
		run_op(4'h8, WC);
		rdchk(data_flash_pkg::IDX_OP_STATUS, 4'h1);
		check(o_irq, 0);
		run_op(4'h8, 0);
		check(n, 0);
		apb(1'b1, data_flash_pkg::IDX_OP_STATUS, 4'h3);
		#1;
		check(o_irq, 1);
		apb(1'b1, data_flash_pkg::IDX_OP_STATUS, 4'h0);
		#1;
		check(o_irq, 0);
		rdchk(data_flash_pkg::IDX_IRQ_STAT, 4'h1);
		apb(1'b1, data_flash_pkg::IDX_IRQ_STAT, 4'h1);
		rdchk(data_flash_pkg::IDX_IRQ_STAT, 4'h0);
		set_addr(18'h00200);
		rdchk(data_flash_pkg::IDX_DATA_HI, 4'hA);
		set_addr(18'h00201);
		rdchk(data_flash_pkg::IDX_DATA_LO, 4'hC);
	endtask : t_prog
	task automatic t_erase;
		apb(1'b1, data_flash_pkg::IDX_IRQ_MASK, 4'h2);
		set_addr(18'h00305); // legal address before erase
		fork
			run_op(4'h4, EC);
			begin
				repeat (12) @(posedge i_sys_clk);
				check(o_fl_addr, 18'h00200);
			end
		join
		check(o_irq, 1);
		apb(1'b1, data_flash_pkg::IDX_IRQ_STAT, 4'h2);
		#1;
		check(o_irq, 0);
		apb(1'b1, data_flash_pkg::IDX_OP_STATUS, 4'h0);
		set_addr(18'h00200);
		rdchk(data_flash_pkg::IDX_DATA_LO, 4'hF);
		apb(1'b0, 6'h3F, 4'h0);
		check(err, 1);
		check(rd, 0);
	endtask : t_erase
	// ************************************************************
	// run control
	// ************************************************************
	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : print_verdict
	initial begin
		i_sys_clk = 1'b0;
		forever #5 i_sys_clk = ~i_sys_clk;
	end
	// watchdog against a hung handshake
	initial begin
		#200000;
		errors++;
		print_verdict();
	end
	initial begin
		errors = 0;
		cmp_count = 0;
		i_rst = 1'b1;
		i_psel = 1'b0;
		i_penable = 1'b0;
		i_pwrite = 1'b0;
		i_paddr = 8'h00;
		i_pwdata = 32'h0;
		repeat (6) @(posedge i_sys_clk);
		i_rst <= 1'b0;
		t_read();
		t_incr();
		t_prog();
		t_erase();
		print_verdict();
	end
endmodule : test_data_flash_access_unit
